// *** rtl/fspd_ctrl.sv ***
// Suspend/resume, deep power-down and release control of a serial flash
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module fspd_ctrl (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic                spi_clk,
  input  wire logic                cs_n,
  input  wire logic                si,
  input  wire logic                eng_start,
  input  wire logic                eng_erase,
  input  wire logic                eng_pgm,
  input  wire logic                eng_done,
  output logic                     so_r,
  output logic                     so_oe_r,
  output fspd_pkg::fspd_sts_s      sts_r,
  output logic                     eng_hold_r,
  output logic                     eng_abort_r,
  output logic                     wel_clear_r,
  output logic                     deep_pd_r,
  output logic                     standby_r,
  output logic                     cmd_valid_r,
  output logic [7:0]               cmd_op_r,
  output logic                     cmd_refused_r
);

  // ----------------------------------------------------------------
  // Link side, rising edge
  // ----------------------------------------------------------------
  logic                lk_first_r;
  fspd_pkg::fspd_frm_s lk_frm_r;
  fspd_pkg::fspd_frm_s lk_frm_nxt;
  logic                lk_tog_r;
  logic                lk_tog_nxt;
  logic                lk_wip_s1_r;
  logic                lk_wip_s2_r;

  // First edge of a frame is marked by the deselect that precedes it
  always_ff @(posedge spi_clk or posedge cs_n)
  begin
    if (cs_n)
      lk_first_r <= 1'b1;
    else
      lk_first_r <= 1'b0;
  end

  always_comb
  begin
    lk_frm_nxt = lk_frm_r;
    lk_tog_nxt = lk_tog_r;
    if (lk_first_r)
    begin
      lk_frm_nxt.op  = {7'h00, si};
      lk_frm_nxt.cnt = 6'h01;
      lk_tog_nxt     = ~lk_tog_r;
    end
    else
    begin
      if (lk_frm_r.cnt < fspd_pkg::OP_BITS)
        lk_frm_nxt.op = {lk_frm_r.op[6:0], si};
      if (lk_frm_r.cnt != fspd_pkg::CNT_SAT)
        lk_frm_nxt.cnt = lk_frm_r.cnt + 6'h01;
    end
  end

  // Frame word is not cleared at deselect: the system side reads it then
  always_ff @(posedge spi_clk or posedge rst)
  begin
    if (rst)
    begin
      lk_frm_r    <= '0;
      lk_tog_r    <= 1'b0;
      lk_wip_s1_r <= 1'b0;
      lk_wip_s2_r <= 1'b0;
    end
    else
    begin
      lk_frm_r    <= lk_frm_nxt;
      lk_tog_r    <= lk_tog_nxt;
      lk_wip_s1_r <= sts_r.write_in_progress_flag;
      lk_wip_s2_r <= lk_wip_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Link side, falling edge: identification output
  // ----------------------------------------------------------------
  logic       so_nxt;
  logic       oe_nxt;
  logic [2:0] id_bit_r;
  logic [2:0] id_bit_nxt;

  always_comb
  begin
    so_nxt     = so_r;
    oe_nxt     = so_oe_r;
    id_bit_nxt = id_bit_r;
    if (lk_frm_r.op == fspd_pkg::OP_RELEASE && lk_frm_r.cnt >= fspd_pkg::ID_BITS &&
        !lk_wip_s2_r)
    begin
      oe_nxt     = 1'b1;
      so_nxt     = fspd_pkg::DEVICE_ID[id_bit_r];
      id_bit_nxt = id_bit_r - 3'h1;
    end
  end

  always_ff @(negedge spi_clk or posedge cs_n)
  begin
    if (cs_n)
    begin
      so_r     <= 1'b0;
      so_oe_r  <= 1'b0;
      id_bit_r <= fspd_pkg::ID_MSB;
    end
    else
    begin
      so_r     <= so_nxt;
      so_oe_r  <= oe_nxt;
      id_bit_r <= id_bit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;
  logic tg_s1_r;
  logic tg_s2_r;
  logic tg_seen_r;

  // Frame word is stable once select is high, so the synced select qualifies it
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_d_r    <= 1'b1;
      tg_s1_r   <= 1'b0;
      tg_s2_r   <= 1'b0;
      tg_seen_r <= 1'b0;
    end
    else
    begin
      cs_s1_r   <= cs_n;
      cs_s2_r   <= cs_s1_r;
      cs_d_r    <= cs_s2_r;
      tg_s1_r   <= lk_tog_r;
      tg_s2_r   <= tg_s1_r;
      tg_seen_r <= (cs_s2_r && !cs_d_r) ? tg_s2_r : tg_seen_r;
    end
  end

  // ----------------------------------------------------------------
  // Command control
  // ----------------------------------------------------------------
  function automatic logic blk_erase(input logic [7:0] op);
    blk_erase = op == fspd_pkg::OP_WRSR_A || op == fspd_pkg::OP_WRSR_B ||
                op == fspd_pkg::OP_WRSR_C || op == fspd_pkg::OP_SEC_ERS ||
                op == fspd_pkg::OP_SE || op == fspd_pkg::OP_BE32 ||
                op == fspd_pkg::OP_BE64 || op == fspd_pkg::OP_CE_A ||
                op == fspd_pkg::OP_CE_B;
  endfunction

  function automatic logic blk_prog(input logic [7:0] op);
    blk_prog = blk_erase(op) || op == fspd_pkg::OP_SEC_PGM ||
               op == fspd_pkg::OP_PP || op == fspd_pkg::OP_QPP;
  endfunction

  function automatic logic own_op(input logic [7:0] op);
    own_op = op == fspd_pkg::OP_SUSPEND || op == fspd_pkg::OP_RESUME ||
             op == fspd_pkg::OP_PWRDN || op == fspd_pkg::OP_RELEASE ||
             op == fspd_pkg::OP_RST_EN || op == fspd_pkg::OP_RST;
  endfunction

  fspd_pkg::fspd_mode_e mode_r;
  fspd_pkg::fspd_mode_e mode_nxt;
  fspd_pkg::fspd_sts_s  sts_nxt;
  logic [9:0]           tmr_r;
  logic [9:0]           tmr_nxt;
  logic [9:0]           sus_tmr_r;
  logic [9:0]           sus_tmr_nxt;
  logic                 sus_wait_r;
  logic                 sus_wait_nxt;
  logic                 kind_ers_r;
  logic                 kind_ers_nxt;
  logic                 kind_pgm_r;
  logic                 kind_pgm_nxt;
  logic                 rst_en_r;
  logic                 rst_en_nxt;
  logic                 hold_nxt;
  logic                 fe;
  logic [7:0]           fop;
  logic                 op_ok;
  logic                 suspended;
  logic                 sus_go;
  logic                 res_go;
  logic                 dp_go;
  logic                 rel_go;
  logic                 sw_go;
  logic                 refuse;
  logic                 pass;

  always_comb
  begin
    fe        = cs_s2_r && !cs_d_r && (tg_s2_r != tg_seen_r);
    fop       = lk_frm_r.op;
    op_ok     = lk_frm_r.cnt >= fspd_pkg::OP_BITS;
    suspended = sts_r.prog_sus || sts_r.erase_sus;
    sus_go = fe && op_ok && mode_r == fspd_pkg::FS_RUN && fop == fspd_pkg::OP_SUSPEND &&
             sts_r.write_in_progress_flag && !suspended && !sus_wait_r && (kind_ers_r || kind_pgm_r);
    res_go = fe && op_ok && mode_r == fspd_pkg::FS_RUN && fop == fspd_pkg::OP_RESUME &&
             suspended && !sts_r.write_in_progress_flag;
    dp_go = fe && mode_r == fspd_pkg::FS_RUN && fop == fspd_pkg::OP_PWRDN &&
            lk_frm_r.cnt == fspd_pkg::OP_BITS && !sts_r.write_in_progress_flag;
    rel_go = fe && mode_r == fspd_pkg::FS_PD && fop == fspd_pkg::OP_RELEASE &&
             (lk_frm_r.cnt == fspd_pkg::OP_BITS || lk_frm_r.cnt >= fspd_pkg::ID_BITS) &&
             !sts_r.write_in_progress_flag;
    sw_go = fe && op_ok && fop == fspd_pkg::OP_RST && rst_en_r &&
            mode_r != fspd_pkg::FS_WAKE;
    refuse = fe && op_ok && mode_r == fspd_pkg::FS_RUN &&
             ((sts_r.prog_sus && blk_prog(fop)) || (sts_r.erase_sus && blk_erase(fop)));
    pass = fe && op_ok && mode_r == fspd_pkg::FS_RUN && !refuse && !own_op(fop);

    mode_nxt     = mode_r;
    tmr_nxt      = tmr_r;
    sts_nxt      = sts_r;
    sus_tmr_nxt  = sus_tmr_r;
    sus_wait_nxt = sus_wait_r;
    kind_ers_nxt = kind_ers_r;
    kind_pgm_nxt = kind_pgm_r;
    hold_nxt     = eng_hold_r;
    rst_en_nxt   = rst_en_r;
    if (fe && op_ok && mode_r != fspd_pkg::FS_WAKE)
      rst_en_nxt = fop == fspd_pkg::OP_RST_EN;

    // Done is ignored while held; the engine is expected to stop on hold
    if (eng_done && !eng_hold_r)
      sts_nxt.write_in_progress_flag = 1'b0;
    if (eng_start)
    begin
      sts_nxt.write_in_progress_flag  = 1'b1;
      kind_ers_nxt = eng_erase;
      kind_pgm_nxt = eng_pgm;
    end

    if (sus_go)
    begin
      sts_nxt.erase_sus = kind_ers_r;
      sts_nxt.prog_sus  = !kind_ers_r;
      hold_nxt          = 1'b1;
      sus_wait_nxt      = 1'b1;
      sus_tmr_nxt       = fspd_pkg::SUS_LOAD;
    end
    else if (sus_wait_r)
    begin
      // Busy drops on the edge that ends the latency, never one cycle past it
      if (sus_tmr_r <= 10'h001)
      begin
        sts_nxt.write_in_progress_flag  = 1'b0;
        sus_wait_nxt = 1'b0;
      end
      else
        sus_tmr_nxt = sus_tmr_r - 10'h001;
    end

    if (res_go)
    begin
      sts_nxt.prog_sus  = 1'b0;
      sts_nxt.erase_sus = 1'b0;
      sts_nxt.write_in_progress_flag       = 1'b1;
      hold_nxt          = 1'b0;
    end

    unique case (mode_r)
      fspd_pkg::FS_RUN:
      begin
        if (dp_go)
        begin
          mode_nxt = fspd_pkg::FS_PDE;
          tmr_nxt  = fspd_pkg::DP_LOAD;
        end
      end
      fspd_pkg::FS_PDE:
      begin
        if (tmr_r == 10'h000)
          mode_nxt = fspd_pkg::FS_PD;
        else
          tmr_nxt = tmr_r - 10'h001;
      end
      fspd_pkg::FS_PD:
      begin
        if (rel_go)
        begin
          mode_nxt = fspd_pkg::FS_WAKE;
          tmr_nxt  = (lk_frm_r.cnt >= fspd_pkg::ID_BITS) ? fspd_pkg::RES2_LOAD
                                                          : fspd_pkg::RES1_LOAD;
        end
      end
      fspd_pkg::FS_WAKE:
      begin
        if (tmr_r == 10'h000)
          mode_nxt = fspd_pkg::FS_RUN;
        else
          tmr_nxt = tmr_r - 10'h001;
      end
      default:
      begin
        mode_nxt = fspd_pkg::FS_RUN;
        tmr_nxt  = 10'h000;
      end
    endcase

    if (sw_go)
    begin
      sts_nxt      = fspd_pkg::STS_RESET;
      sts_nxt.output_drive_bit0 = sts_r.output_drive_bit0;
      hold_nxt     = 1'b0;
      sus_wait_nxt = 1'b0;
      mode_nxt     = fspd_pkg::FS_RUN;
      tmr_nxt      = 10'h000;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_r        <= fspd_pkg::FS_RUN;
      tmr_r         <= 10'h000;
      sts_r         <= fspd_pkg::STS_RESET;
      sus_tmr_r     <= 10'h000;
      sus_wait_r    <= 1'b0;
      kind_ers_r    <= 1'b0;
      kind_pgm_r    <= 1'b0;
      rst_en_r      <= 1'b0;
      eng_hold_r    <= 1'b0;
      eng_abort_r   <= 1'b0;
      wel_clear_r   <= 1'b0;
      deep_pd_r     <= 1'b0;
      standby_r     <= 1'b1;
      cmd_valid_r   <= 1'b0;
      cmd_op_r      <= 8'h00;
      cmd_refused_r <= 1'b0;
    end
    else
    begin
      mode_r        <= mode_nxt;
      tmr_r         <= tmr_nxt;
      sts_r         <= sts_nxt;
      sus_tmr_r     <= sus_tmr_nxt;
      sus_wait_r    <= sus_wait_nxt;
      kind_ers_r    <= kind_ers_nxt;
      kind_pgm_r    <= kind_pgm_nxt;
      rst_en_r      <= rst_en_nxt;
      eng_hold_r    <= hold_nxt;
      eng_abort_r   <= sw_go;
      wel_clear_r   <= sw_go;
      deep_pd_r     <= mode_nxt == fspd_pkg::FS_PD;
      standby_r     <= cs_s2_r && !sts_nxt.write_in_progress_flag && mode_nxt == fspd_pkg::FS_RUN;
      cmd_valid_r   <= pass;
      cmd_op_r      <= (pass || refuse) ? fop : cmd_op_r;
      cmd_refused_r <= refuse;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  localparam int SUS_BOUND  = fspd_pkg::SUS_CYC;
  localparam int RESW_BOUND = fspd_pkg::RESW_CYC;
  localparam int DP_BOUND   = fspd_pkg::DP_CYC;
  localparam int WAKE_BOUND = fspd_pkg::RES1_CYC;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sus_flag_a: assert property (sus_go |=> (sts_r.prog_sus || sts_r.erase_sus) && eng_hold_r)
    else $error("suspend flag not set at once");
  sus_wip_a: assert property (sus_go |-> ##[1:SUS_BOUND] !sts_r.write_in_progress_flag)
    else $error("busy flag not cleared within suspend latency");
  sus_ignore_a: assert property (fe && fop == fspd_pkg::OP_SUSPEND && suspended |=>
    $stable({sts_r.prog_sus, sts_r.erase_sus}))
    else $error("suspend taken while already suspended");
  res_take_a: assert property (res_go |=> !suspended ##[0:RESW_BOUND] sts_r.write_in_progress_flag)
    else $error("resume did not restart the cycle");
  res_ignore_a: assert property (fe && fop == fspd_pkg::OP_RESUME && !suspended &&
    !eng_start && !eng_done && !sus_wait_r |=> $stable(sts_r.write_in_progress_flag))
    else $error("resume acted with no suspend");
  prog_refuse_a: assert property (fe && op_ok && mode_r == fspd_pkg::FS_RUN &&
    sts_r.prog_sus && fop == fspd_pkg::OP_SEC_PGM |=> cmd_refused_r && !cmd_valid_r)
    else $error("program sent while program suspended");
  ers_allow_a: assert property (fe && op_ok && mode_r == fspd_pkg::FS_RUN &&
    sts_r.erase_sus && !sts_r.prog_sus && fop == fspd_pkg::OP_PP |=> cmd_valid_r)
    else $error("program refused during erase suspend");
  dp_len_a: assert property (fe && fop == fspd_pkg::OP_PWRDN &&
    lk_frm_r.cnt != fspd_pkg::OP_BITS |=> mode_r != fspd_pkg::FS_PDE)
    else $error("power-down taken with wrong bit count");
  dp_busy_a: assert property (fe && sts_r.write_in_progress_flag && mode_r == fspd_pkg::FS_RUN |=>
    mode_r == fspd_pkg::FS_RUN)
    else $error("power-down taken while busy");
  dp_delay_a: assert property (dp_go |=> !deep_pd_r ##[DP_BOUND:DP_BOUND] deep_pd_r)
    else $error("power-down entered at wrong time");
  pd_ignore_a: assert property (fe && mode_r == fspd_pkg::FS_PD &&
    fop != fspd_pkg::OP_RELEASE && fop != fspd_pkg::OP_RST |=> deep_pd_r && !cmd_valid_r)
    else $error("command acted in power-down");
  wake_hold_a: assert property (rel_go |=> !cmd_valid_r[*8] ##[0:WAKE_BOUND]
    mode_r == fspd_pkg::FS_RUN)
    else $error("release delay not kept");
  sw_reset_a: assert property (sw_go |=> !suspended && !deep_pd_r && wel_clear_r)
    else $error("software reset left state behind");
  power_up_a: assert property ($fell(rst) |-> sts_r == fspd_pkg::STS_RESET &&
    !deep_pd_r && !eng_hold_r)
    else $error("wrong state after power-up");

  sus_res_c: cover property (sus_go ##[1:1000] res_go);
  dp_wake_c: cover property (dp_go ##[1:1000] rel_go ##[1:1000] mode_r == fspd_pkg::FS_RUN);
  refuse_c: cover property (cmd_refused_r);
  sw_reset_c: cover property (sw_go && suspended);

endmodule
`default_nettype wire

// *** rtl/fspd_pkg.sv ***
// Opcodes, timing, reset values and carriers of the suspend/power-down control
package fspd_pkg;
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned NS_PER_CYC = 1_000_000_000 / CLK_HZ;

  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7a;
  localparam logic [7:0] OP_PWRDN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_WRSR_A  = 8'h01;
  localparam logic [7:0] OP_WRSR_B  = 8'h31;
  localparam logic [7:0] OP_WRSR_C  = 8'h11;
  localparam logic [7:0] OP_SEC_ERS = 8'h44;
  localparam logic [7:0] OP_SEC_PGM = 8'h42;
  localparam logic [7:0] OP_SE      = 8'h20;
  localparam logic [7:0] OP_BE32    = 8'h52;
  localparam logic [7:0] OP_BE64    = 8'hd8;
  localparam logic [7:0] OP_CE_A    = 8'hc7;
  localparam logic [7:0] OP_CE_B    = 8'h60;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_QPP     = 8'h32;

  // Fill value of an erased array byte
  localparam logic [7:0] ARRAY_ERASED = 8'hff;
  // Arbitrary identification value
  localparam logic [7:0] DEVICE_ID    = 8'h5a;

  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] ID_BITS = 6'h20;
  localparam logic [5:0] CNT_SAT = 6'h3f;
  localparam logic [2:0] ID_MSB  = 3'h7;

  localparam int unsigned T_SUS_NS  = 40_000;
  localparam int unsigned T_RESW_NS = 200;
  localparam int unsigned T_DP_NS   = 3_000;
  localparam int unsigned T_RES1_NS = 8_000;
  localparam int unsigned T_RES2_NS = 8_000;
  // Longest times round down, least times round up
  localparam int unsigned SUS_CYC  = T_SUS_NS / NS_PER_CYC;
  localparam int unsigned RESW_CYC = T_RESW_NS / NS_PER_CYC;
  localparam int unsigned DP_CYC   = (T_DP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned RES1_CYC = (T_RES1_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned RES2_CYC = (T_RES2_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam logic [9:0]  SUS_LOAD  = 10'(SUS_CYC - 1);
  localparam logic [9:0]  DP_LOAD   = 10'(DP_CYC - 1);
  localparam logic [9:0]  RES1_LOAD = 10'(RES1_CYC - 1);
  localparam logic [9:0]  RES2_LOAD = 10'(RES2_CYC - 1);

  typedef enum logic [3:0] {
    FS_RUN  = 4'h1,
    FS_PDE  = 4'h2,
    FS_PD   = 4'h4,
    FS_WAKE = 4'h8
  } fspd_mode_e;

  typedef struct packed {
    logic output_drive_bit0;
    logic erase_sus;
    logic prog_sus;
    logic write_in_progress_flag;
  } fspd_sts_s;

  typedef struct packed {
    logic [7:0] op;
    logic [5:0] cnt;
  } fspd_frm_s;

  localparam fspd_sts_s STS_RESET = 4'h8;
endpackage

// *** verif/fspd_host.sv ***
// Host serial controller model that frames commands for the control block
`timescale 1ns/10ps
`default_nettype none
module fspd_host (
  output logic      spi_clk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial
  begin
    spi_clk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // MSB first, set up before rise
  // Deselect right after the last bit
  task automatic frame(input logic [31:0] d, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n = 1'b0;
    #23;
    for (int i = 0; i < n; i++)
    begin
      si = (i < 32) ? d[31-i] : ~si;
      #80 spi_clk = 1'b1;
      if (i >= 32)
        rd = {rd[14:0], so};
      #80 spi_clk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Released line flips, so a stale level is never taken for data
    si = ~si;
  endtask
endmodule
`default_nettype wire

// *** verif/fspd_ctrl_test.sv ***
// Self-checking bench for the suspend and power-down control block
`timescale 1ns/10ps
`default_nettype none
module fspd_ctrl_test;
  logic                sys_clk, rst;
  logic                eng_start, eng_erase, eng_pgm, eng_done;
  wire                 spi_clk, cs_n, si;
  logic                so_r, so_oe_r, eng_hold_r, eng_abort_r, wel_clear_r;
  logic                deep_pd_r, standby_r, cmd_valid_r, cmd_refused_r;
  logic [7:0]          cmd_op_r;
  fspd_pkg::fspd_sts_s sts_r;
  logic                ref_seen, val_seen, abt_seen, wel_seen;
  logic [15:0]         rd_id;
  int                  err_count = 0;
  int                  compares = 0;

  fspd_ctrl dut (.sys_clk(sys_clk), .rst(rst), .spi_clk(spi_clk), .cs_n(cs_n), .si(si),
    .eng_start(eng_start), .eng_erase(eng_erase), .eng_pgm(eng_pgm), .eng_done(eng_done),
    .so_r(so_r), .so_oe_r(so_oe_r), .sts_r(sts_r), .eng_hold_r(eng_hold_r),
    .eng_abort_r(eng_abort_r), .wel_clear_r(wel_clear_r), .deep_pd_r(deep_pd_r),
    .standby_r(standby_r), .cmd_valid_r(cmd_valid_r), .cmd_op_r(cmd_op_r),
    .cmd_refused_r(cmd_refused_r));
  fspd_host host (.spi_clk(spi_clk), .cs_n(cs_n), .si(si), .so(so_r));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Pulses last one cycle, so they are caught and held here
  always @(posedge sys_clk)
  begin
    ref_seen <= ref_seen | cmd_refused_r;
    val_seen <= val_seen | cmd_valid_r;
    abt_seen <= abt_seen | eng_abort_r;
    wel_seen <= wel_seen | wel_clear_r;
  end

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Polls status busy (sel 0) or power-down (sel 1)
  task automatic wait_lvl(input int sel, input logic v, input int lim, output int n);
    n = 0;
    while (((sel == 0) ? sts_r.write_in_progress_flag : deep_pd_r) !== v)
    begin
      @(negedge sys_clk);
      n++;
      if (n > lim)
      begin
        err_count++;
        $display("Error wait %0d expected %b seen timeout", sel, v);
        end_sim;
      end
    end
  endtask
  // End of frame shows at the outputs two to three cycles after deselect
  task automatic cmd(input logic [7:0] op, input int n);
    ref_seen = 1'b0;
    val_seen = 1'b0;
    abt_seen = 1'b0;
    wel_seen = 1'b0;
    host.frame({op, 24'h000000}, n, rd_id);
    repeat (6) @(negedge sys_clk);
  endtask
  // Bits are start, erase, program, done
  task automatic eng(input logic [3:0] v);
    @(negedge sys_clk);
    {eng_start, eng_erase, eng_pgm, eng_done} = v;
    @(negedge sys_clk);
    eng_start = 1'b0;
    eng_done = 1'b0;
  endtask

  task automatic t_idle;
    chk("sts_rst", 8'h08, {4'h0, sts_r});
    chk("pd_sb", 8'h01, {6'h00, deep_pd_r, standby_r});
    cmd(8'h75, 8);
    cmd(8'h7a, 8);
    chk("sts_idle", 8'h08, {4'h0, sts_r});
    eng(4'b1000);
    cmd(8'h75, 8);
    chk("sts_wr", 8'h09, {4'h0, sts_r});
    eng(4'b0001);
  endtask
  task automatic t_susp(input logic er);
    logic [7:0] ops [12] = '{8'h01, 8'h31, 8'h11, 8'h44, 8'h20, 8'h52,
                             8'hd8, 8'hc7, 8'h60, 8'h42, 8'h02, 8'h32};
    logic       rf;
    int         n;
    eng({1'b1, er, ~er, 1'b0});
    chk("standby", 8'h00, 8'(standby_r));
    cmd(8'h75, 8);
    chk("sts_sus", {5'h01, er, ~er, 1'b1}, {4'h0, sts_r});
    chk("hold", 8'h01, 8'(eng_hold_r));
    wait_lvl(0, 1'b0, fspd_pkg::SUS_CYC, n);
    chk("sus_lat", 8'h01, 8'(n > fspd_pkg::SUS_CYC - 10));
    cmd(8'h75, 8);
    chk("sts_twice", {5'h01, er, ~er, 1'b0}, {4'h0, sts_r});
    for (int i = 0; i < 12; i++)
    begin
      rf = (i < 9) || !er;
      cmd(ops[i], 8);
      chk("refused", 8'(rf), 8'(ref_seen));
      chk("passed", 8'(!rf), 8'(val_seen));
      chk("op", ops[i], cmd_op_r);
    end
    cmd(8'h7a, 8);
    chk("sts_res", 8'h09, {4'h0, sts_r});
    chk("hold", 8'h00, 8'(eng_hold_r));
    eng(4'b0001);
    chk("sts_done", 8'h08, {4'h0, sts_r});
  endtask
  task automatic t_pd;
    int n;
    eng(4'b1010);
    cmd(8'hb9, 8);
    cmd(8'hab, 8);
    repeat (40) @(negedge sys_clk);
    chk("pd_busy", 8'h00, 8'(deep_pd_r));
    chk("sts_busy", 8'h09, {4'h0, sts_r});
    eng(4'b0001);
    cmd(8'hb9, 9);
    repeat (40) @(negedge sys_clk);
    chk("pd_len", 8'h00, 8'(deep_pd_r));
    cmd(8'hb9, 8);
    chk("pd_early", 8'h00, 8'(deep_pd_r));
    wait_lvl(1, 1'b1, fspd_pkg::DP_CYC, n);
    chk("pd_lat", 8'h01, 8'(n > fspd_pkg::DP_CYC - 10));
    chk("standby", 8'h00, 8'(standby_r));
    cmd(8'h75, 8);
    cmd(8'h02, 8);
    chk("pd_ign", 8'h01, {6'h00, ref_seen | val_seen, deep_pd_r});
    cmd(8'hab, 8);
    chk("pd_rel", 8'h00, 8'(deep_pd_r));
    cmd(8'hb9, 8);
    repeat (40) @(negedge sys_clk);
    chk("rel_blk", 8'h00, 8'(deep_pd_r));
    // Host stays deselected for release delay
    repeat (fspd_pkg::RES1_CYC) @(negedge sys_clk);
    cmd(8'hb9, 8);
    wait_lvl(1, 1'b1, fspd_pkg::DP_CYC, n);
    cmd(8'hab, 48);
    chk("id_pd", fspd_pkg::DEVICE_ID, rd_id[15:8]);
    chk("pd_rel2", 8'h00, 8'(deep_pd_r));
    // Host stays deselected for second delay
    repeat (fspd_pkg::RES2_CYC) @(negedge sys_clk);
  endtask
  task automatic t_id;
    cmd(8'hab, 48);
    chk("id_a", fspd_pkg::DEVICE_ID, rd_id[15:8]);
    chk("id_b", fspd_pkg::DEVICE_ID, rd_id[7:0]);
    chk("so_off", 8'h00, {6'h00, so_oe_r, so_r});
  endtask
  task automatic t_rst;
    eng(4'b1100);
    cmd(8'h75, 8);
    cmd(8'h66, 8);
    cmd(8'h99, 8);
    chk("sts_sw", 8'h08, {4'h0, sts_r});
    chk("abort", 8'h03, {6'h00, abt_seen, wel_seen});
    eng(4'b1010);
    cmd(8'h75, 8);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    chk("sts_pwr", 8'h08, {4'h0, sts_r});
    chk("hold_pwr", 8'h00, 8'(eng_hold_r));
  endtask

  initial
  begin
    {eng_start, eng_erase, eng_pgm, eng_done} = 4'h0;
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    t_idle;
    t_susp(1'b0);
    t_susp(1'b1);
    t_pd;
    t_id;
    t_rst;
    end_sim;
  end
endmodule
`default_nettype wire
